/* bench/spl_partner.sv */
// far side of the link: slave to a master device, master to a slave device
// assumes the bench resolves shared lines and calls xfer for frames it masters
`default_nettype none
module spl_partner #(
  parameter int W = 8
) (
  input  wire logic         cpol_i,
  input  wire logic         cpha_i,
  input  wire logic         sclk_i,
  input  wire logic         sel_n_i,
  input  wire logic         mosi_i,
  input  wire logic         miso_i,
  input  wire logic [W-1:0] tx_i,
  output var  logic         sclk_o,
  output var  logic         ss_n_o,
  output var  logic         mosi_o,
  output var  logic         miso_o,
  output var  logic         miso_oe_o,
  output var  logic [W-1:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b1;
    miso_o = 1'b1;
    miso_oe_o = 1'b0;
    rx_o = '0;
  end
  // slave role: with phase 0 the first bit is out before the leading edge
  always @(negedge sel_n_i) begin
    miso_oe_o = 1'b1;
    idx = cpha_i ? W - 1 : W - 2;
    miso_o = cpha_i ? ~tx_i[W-1] : tx_i[W-1];
  end
  always @(posedge sel_n_i) begin
    miso_oe_o = 1'b0;
  end
  always @(sclk_i) begin
    if (!sel_n_i && (sclk_i == (cpol_i ~^ cpha_i))) begin
      rx_o = {rx_o[W-2:0], mosi_i};
    end else if (!sel_n_i && idx >= 0) begin
      miso_o = tx_i[idx];
      idx--;
    end
  end
  // master role: one frame of W bits, clock still outside it, 64 ns period
  task automatic xfer(input logic [W-1:0] w, input logic sel, output logic [W-1:0] r);
    sclk_o = cpol_i;
    #7;
    ss_n_o = ~sel;
    if (!cpha_i) mosi_o = w[W-1];
    // lead time covers the synchronised select that enables the slave data output
    #160;
    for (int i = W - 1; i >= 0; i--) begin
      sclk_o = ~sclk_o;
      if (cpha_i) mosi_o = w[i];
      else r[i] = miso_i;
      #32;
      sclk_o = ~sclk_o;
      if (cpha_i) r[i] = miso_i;
      else if (i > 0) mosi_o = w[i-1];
      #32;
    end
    ss_n_o = 1'b1;
    mosi_o = 1'b1;
  endtask : xfer
endmodule : spl_partner
`default_nettype wire

/* bench/tb.sv */
// self-checking bench of the serial port: master, buffer, multimaster, slave, flag pins
// assumes spl_partner models the far side; pull-ups on the shared serial lines
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 8;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, master_mode_i = 1'b0, clk_pol_i = 1'b0;
  logic clk_pha_i = 1'b0, mm_err_clr_i = 1'b0, overrun_clr_i = 1'b0, tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b0, timer_expiry_i = 1'b0, ss_drv = 1'b1;
  logic [7:0] clk_div_i = 8'h00, flag_mode_i = 8'h00;
  logic [3:0] flag_out_val_i = 4'h0, flag_sel_en_i = 4'h0, flag_ext = 4'hf;
  logic [3:0] flag_level_o, flag_pin_o, flag_pin_oe_o;
  logic [3:0] oe_e [4] = '{4'h0, 4'hf, 4'h8, 4'hf};
  logic [3:0] o_e [4] = '{4'h0, 4'ha, 4'h8, 4'hf};
  logic [W-1:0] tx_word_i = '0, rx_word_o, p_tx = '0, p_rx, r;
  logic tx_ready_o, rx_valid_o, busy_o, mm_err_o, overrun_o, serial_clock_pin_o;
  logic serial_clock_pin_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic p_sclk, p_ss_n, p_mosi, p_miso, p_miso_oe;
  logic [2:0] irq_req_o;
  wire logic serial_clock_pin_i, mosi_i, miso_i, slave_select_input_n_i;
  wire logic [3:0] flag_pin_i;
  int error_cnt = 0, num_checks = 0, tgl = 0;
  realtime t0, t1;
  always #20 clk_sys_i = ~clk_sys_i;
  assign serial_clock_pin_i = serial_clock_pin_oe_o ? serial_clock_pin_o : p_sclk;
  assign mosi_i = mosi_oe_o ? mosi_o : p_mosi;
  assign miso_i = miso_oe_o ? miso_o : (p_miso_oe ? p_miso : 1'b1);
  assign flag_pin_i = (flag_pin_oe_o & flag_pin_o) | (~flag_pin_oe_o & flag_ext);
  assign slave_select_input_n_i = p_ss_n & ss_drv;
  spl_top #(.W(W)) spl_top_inst (.clk_sys_i, .rstn_i, .master_mode_i, .clk_pol_i, .clk_pha_i,
    .clk_div_i, .flag_mode_i, .flag_out_val_i, .flag_sel_en_i, .timer_expiry_i, .mm_err_clr_i,
    .overrun_clr_i, .tx_valid_i, .tx_word_i, .tx_ready_o, .rx_valid_o, .rx_word_o, .rx_ready_i,
    .busy_o, .mm_err_o, .overrun_o, .flag_level_o, .irq_req_o, .serial_clock_pin_i,
    .serial_clock_pin_o, .serial_clock_pin_oe_o, .slave_select_input_n_i, .mosi_i, .mosi_o,
    .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .flag_pin_i, .flag_pin_o, .flag_pin_oe_o);
  spl_partner #(.W(W)) spl_partner_inst (.cpol_i(clk_pol_i), .cpha_i(clk_pha_i),
    .sclk_i(serial_clock_pin_i), .sel_n_i(&flag_pin_i), .mosi_i(mosi_i), .miso_i(miso_i),
    .tx_i(p_tx), .sclk_o(p_sclk), .ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso),
    .miso_oe_o(p_miso_oe), .rx_o(p_rx));
  // serial clock edges made by the master engine
  always @(serial_clock_pin_o) begin
    if (busy_o === 1'b1 && serial_clock_pin_oe_o === 1'b1) begin
      if (tgl == 0) t0 = $realtime;
      t1 = $realtime;
      tgl++;
    end
  end
  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [W-1:0] w);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    tx_valid_i = 1'b1;
    tx_word_i = w;
    while (tx_ready_o !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("tx_taken", n < 2000, 1'b1);
    @(negedge clk_sys_i);
    tx_valid_i = 1'b0;
  endtask : send
  task automatic recv(output logic [W-1:0] w);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    rx_ready_i = 1'b1;
    while (rx_valid_o !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("rx_taken", n < 2000, 1'b1);
    w = rx_word_o;
    @(negedge clk_sys_i);
    rx_ready_i = 1'b0;
  endtask : recv
  task automatic idle_wait;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("idle_reached", n < 2000, 1'b1);
  endtask : idle_wait
  task automatic mst(input logic pol, pha, input logic [7:0] dv, input int pin,
                     input logic [W-1:0] tw, pw);
    @(negedge clk_sys_i);
    master_mode_i = 1'b1;
    clk_pol_i = pol;
    clk_pha_i = pha;
    clk_div_i = dv;
    flag_mode_i = 8'h03 << (2 * pin);
    flag_sel_en_i = 4'h1 << pin;
    p_tx = pw;
    tgl = 0;
    send(tw);
    idle_wait();
    recv(r);
    chk("sclk_edges", tgl, 2 * W);
    chk("sclk_span", int'(t1 - t0), (2 * W - 1) * (dv + 3) * 40);
    chk("far_rx", p_rx, tw);
    chk("near_rx", r, pw);
    chk("sclk_idle", serial_clock_pin_o, pol);
  endtask : mst
  task automatic slv(input logic pol, pha, input logic [W-1:0] a, b, c);
    logic [W-1:0] f;
    @(negedge clk_sys_i);
    master_mode_i = 1'b0;
    clk_pol_i = pol;
    clk_pha_i = pha;
    flag_mode_i = 8'h00;
    send(b);
    chk("miso_off", miso_oe_o, 1'b0);
    spl_partner_inst.xfer(a, 1'b1, f);
    recv(r);
    chk("slave_rx", r, a);
    spl_partner_inst.xfer(c, 1'b1, f);
    chk("slave_tx", f, b);
    recv(r);
    chk("slave_rx2", r, c);
    spl_partner_inst.xfer(8'h5a, 1'b0, f);
    repeat (20) @(negedge clk_sys_i);
    chk("deselected", rx_valid_o, 1'b0);
    chk("no_mm_err", mm_err_o, 1'b0);
    chk("no_overrun", overrun_o, 1'b0);
  endtask : slv
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("flag_oe_rst", flag_pin_oe_o, 4'h0);
    chk("miso_oe_rst", miso_oe_o, 1'b0);
    chk("sclk_oe_rst", serial_clock_pin_oe_o, 1'b0);
    for (int i = 0; i < 4; i++) mst(i[1], i[0], 8'(2 * i), i, 8'h81 ^ 8'(i), 8'h3c + 8'(i));
    // receive path: buffer holds two, push stage a third, fourth stalls the master
    for (int k = 0; k < 4; k++) begin
      p_tx = 8'hc0 + 8'(k);
      send(8'h30 + 8'(k));
      if (k < 3) idle_wait();
    end
    repeat (300) @(negedge clk_sys_i);
    chk("stall_busy", busy_o, 1'b1);
    chk("stall_tx_rdy", tx_ready_o, 1'b0);
    for (int k = 0; k < 4; k++) begin
      recv(r);
      chk("buf_word", r, 8'hc0 + 8'(k));
    end
    ss_drv = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk("mm_err_set", mm_err_o, 1'b1);
    ss_drv = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    mm_err_clr_i = 1'b1;
    @(negedge clk_sys_i);
    mm_err_clr_i = 1'b0;
    @(negedge clk_sys_i);
    chk("mm_err_clr", mm_err_o, 1'b0);
    for (int i = 0; i < 4; i++) slv(i[1], i[0], 8'hc3 ^ 8'(i), 8'h81 + 8'(i), 8'h3e + 8'(i));
    master_mode_i = 1'b1;
    flag_ext = 4'h5;
    flag_out_val_i = 4'ha;
    timer_expiry_i = 1'b1;
    flag_sel_en_i = 4'h0;
    for (int m = 0; m < 4; m++) begin
      flag_mode_i = {4{m[1:0]}};
      repeat (4) @(negedge clk_sys_i);
      chk("flag_oe", flag_pin_oe_o, oe_e[m]);
      chk("flag_out", flag_pin_o & oe_e[m], o_e[m]);
      if (m == 0) chk("flag_in", flag_level_o, 4'h5);
      if (m == 2) chk("irq", irq_req_o, 3'h2);
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

/* inc/spl_pkg.sv */
// types of the serial peripheral pin-level port
// assumes spl_regs.svh is on the include path
`default_nettype none
package spl_pkg;
  `include "spl_regs.svh"

  typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL, M_DONE} spl_mst_st_t;

  typedef struct packed {
    logic                  master;
    logic                  cpol;
    logic                  cpha;
    logic [`SPL_DIV_W-1:0] div;
  } spl_ctl_t;
endpackage : spl_pkg
`default_nettype wire

/* inc/spl_regs.svh */
// constants of the serial peripheral pin-level port
// included by the package; holds defines only
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

// default word length in bits
`define SPL_WORD_W      8
// width of the serial clock rate setting
`define SPL_DIV_W       8
// shortest half period of the master serial clock, in system cycles
`define SPL_MIN_HALF    3
// number of multiplexed flag pins
`define SPL_FLAG_N      4
// per-pin flag mode codes
`define SPL_FMODE_IN    2'h0
`define SPL_FMODE_OUT   2'h1
`define SPL_FMODE_ALT   2'h2
`define SPL_FMODE_SEL   2'h3
// index of the flag pin whose alternate use is timer expiry
`define SPL_TMR_PIN     3
// reset values of the serial control settings
`define SPL_MASTER_RST  1'h0
`define SPL_CPOL_RST    1'h0
`define SPL_CPHA_RST    1'h0
`define SPL_DIV_RST     8'h00

`endif

/* inc/spl_stream_if.sv */
// valid/ready word stream between the port and its receive buffer
// assumes one clock domain on both ends
`default_nettype none
interface spl_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : spl_stream_if
`default_nettype wire

/* verilog/spl_buf2.sv */
// two-entry buffer on the receive word path
// assumes both stream ends run on clk_sys_i
`default_nettype none
module spl_buf2 #(
  parameter int W = 8
) (
  input  wire logic   clk_sys_i,
  input  wire logic   rstn_i,
  spl_stream_if.snk   in_s,
  spl_stream_if.src   out_s
);
  import spl_pkg::*;

  typedef struct packed {
    logic         hv;
    logic         tv;
    logic         rdy;
    logic [W-1:0] hd;
    logic [W-1:0] td;
  } spl_buf_t;

  spl_buf_t b_reg;
  spl_buf_t b_next;
  logic     pop;
  logic     push;

  if (W < 1) begin : g_chk
    $error("spl_buf2: word width must be at least one");
  end

  always_comb begin
    b_next = b_reg;
    pop    = b_reg.hv && out_s.ready;
    push   = in_s.valid && b_reg.rdy;
    if (pop) begin
      if (b_reg.tv) begin
        b_next.hd = b_reg.td;
        b_next.tv = 1'b0;
      end else begin
        b_next.hv = 1'b0;
      end
    end
    if (push) begin
      if (!b_next.hv) begin
        b_next.hv = 1'b1;
        b_next.hd = in_s.data;
      end else begin
        b_next.tv = 1'b1;
        b_next.td = in_s.data;
      end
    end
    b_next.rdy = !b_next.tv;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

  assign in_s.ready  = b_reg.rdy;
  assign out_s.valid = b_reg.hv;
  assign out_s.data  = b_reg.hd;
endmodule : spl_buf2
`default_nettype wire

/* verilog/spl_top.sv */
// serial peripheral port at pin level: master engine, slave shifter, flag pins
// assumes pins pass through an outside pad ring that resolves output enables
// How it works
// - as master, one serial clock cycle is made for every data bit moved.
// - the master serial clock toggles only during a transfer, for exactly one word.
// - as slave, serial clock edges are ignored while slave select is high.
// - data is launched on one serial clock edge and sampled on the opposite edge.
// - clock polarity and phase settings together pick the transfer format.
// - as master, the serial clock rate is selectable.
// - a low slave select chooses the device as slave, acting as its chip select.
// - slave select going low while master raises a sticky multimaster error.
// - as master, any flag pin may drive the far slave's select input.
// - each flag pin is a general flag, interrupt or timer expiry, or a master select; all reset to inputs.
// - master sends on MOSI and receives on MISO; slave does the reverse.
`default_nettype none
module spl_top
  import spl_pkg::*;
#(
  parameter int W     = `SPL_WORD_W,
  parameter int DIV_W = `SPL_DIV_W
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  input  wire logic                    master_mode_i,
  input  wire logic                    clk_pol_i,
  input  wire logic                    clk_pha_i,
  input  wire logic [DIV_W-1:0]        clk_div_i,
  input  wire logic [2*`SPL_FLAG_N-1:0] flag_mode_i,
  input  wire logic [`SPL_FLAG_N-1:0]  flag_out_val_i,
  input  wire logic [`SPL_FLAG_N-1:0]  flag_sel_en_i,
  input  wire logic                    timer_expiry_i,
  input  wire logic                    mm_err_clr_i,
  input  wire logic                    overrun_clr_i,
  input  wire logic                    tx_valid_i,
  input  wire logic [W-1:0]            tx_word_i,
  output var  logic                    tx_ready_o,
  output var  logic                    rx_valid_o,
  output var  logic [W-1:0]            rx_word_o,
  input  wire logic                    rx_ready_i,
  output var  logic                    busy_o,
  output var  logic                    mm_err_o,
  output var  logic                    overrun_o,
  output var  logic [`SPL_FLAG_N-1:0]  flag_level_o,
  output var  logic [2:0]              irq_req_o,
  input  wire logic                    serial_clock_pin_i,
  output var  logic                    serial_clock_pin_o,
  output var  logic                    serial_clock_pin_oe_o,
  input  wire logic                    slave_select_input_n_i,
  input  wire logic                    mosi_i,
  output var  logic                    mosi_o,
  output var  logic                    mosi_oe_o,
  input  wire logic                    miso_i,
  output var  logic                    miso_o,
  output var  logic                    miso_oe_o,
  input  wire logic [`SPL_FLAG_N-1:0]  flag_pin_i,
  output var  logic [`SPL_FLAG_N-1:0]  flag_pin_o,
  output var  logic [`SPL_FLAG_N-1:0]  flag_pin_oe_o
);
  import spl_pkg::*;

  localparam int CW = $clog2(W);
  localparam int HW = DIV_W + 2;

  if (W < 2 || DIV_W != `SPL_DIV_W) begin : g_chk
    $error("spl_top: word width below two or unsupported rate setting width");
  end

  typedef struct packed {
    spl_ctl_t                 serial_control_reg;
    spl_mst_st_t              st;
    logic [HW-1:0]            hcnt;
    logic [CW-1:0]            bcnt;
    logic [W-1:0]             txsh;
    logic [W-1:0]             rxsh;
    logic                     sclk;
    logic                     sclk_oe;
    logic                     mosi;
    logic                     mosi_oe;
    logic                     miso_oe;
    logic                     busy;
    logic                     mm_err;
    logic                     overrun;
    logic                     tx_rdy;
    logic [1:0]               miso_s;
    logic [1:0]               ss_s;
    logic [2:0]               rxt_s;
    logic [1:0]               ack_s;
    logic                     htgl;
    logic                     hs_pend;
    logic [W-1:0]             slv_tx;
    logic [`SPL_FLAG_N-1:0]   fl_s1;
    logic [`SPL_FLAG_N-1:0]   fl_s2;
    logic [`SPL_FLAG_N-1:0]   fl_o;
    logic [`SPL_FLAG_N-1:0]   fl_oe;
    logic [2:0]               irq;
    logic                     push;
    logic [W-1:0]             push_data;
  } spl_sys_t;

  typedef struct packed {
    logic [W-1:0] rx_word;
    logic         rxt;
    logic         ack;
    logic [1:0]   hs_s;
    logic [W-1:0] tx_buf;
  } spl_link_t;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [W-1:0]  sh;
  } spl_frame_t;

  spl_sys_t      r_reg;
  spl_sys_t      r_next;
  spl_link_t     lk_reg;
  spl_link_t     lk_next;
  spl_frame_t    fr_reg;
  spl_frame_t    fr_next;
  logic [CW-1:0] lcnt_reg;
  logic [CW-1:0] lidx;
  logic [HW-1:0] half_m1;
  logic [1:0]    fmode;
  logic          slv_clk;
  logic          frame_rst_n;
  logic          last_bit;

  spl_stream_if #(.W(W)) rx_in_if ();
  spl_stream_if #(.W(W)) rx_out_if ();

  spl_buf2 #(.W(W)) u_rx_buf (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .in_s      (rx_in_if.snk),
    .out_s     (rx_out_if.src)
  );

  assign rx_in_if.valid  = r_reg.push;
  assign rx_in_if.data   = r_reg.push_data;
  assign rx_out_if.ready = rx_ready_i;
  assign rx_valid_o      = rx_out_if.valid;
  assign rx_word_o       = rx_out_if.data;

  // system side: master engine, slave handover, flag pins
  always_comb begin
    r_next        = r_reg;
    half_m1       = HW'(`SPL_MIN_HALF - 1) + HW'(r_reg.serial_control_reg.div);
    last_bit      = (r_reg.bcnt == CW'(W - 1));
    fmode         = 2'h0;
    r_next.miso_s = {r_reg.miso_s[0], miso_i};
    r_next.ss_s   = {r_reg.ss_s[0], slave_select_input_n_i};
    r_next.rxt_s  = {r_reg.rxt_s[1:0], lk_reg.rxt};
    r_next.ack_s  = {r_reg.ack_s[0], lk_reg.ack};
    r_next.fl_s1  = flag_pin_i;
    r_next.fl_s2  = r_reg.fl_s1;
    if (rx_in_if.ready) begin
      r_next.push = 1'b0;
    end
    if (mm_err_clr_i) begin
      r_next.mm_err = 1'b0;
    end
    if (overrun_clr_i) begin
      r_next.overrun = 1'b0;
    end
    if (r_reg.st == M_IDLE && r_reg.ss_s[1]) begin
      r_next.serial_control_reg = '{master_mode_i, clk_pol_i, clk_pha_i, clk_div_i};
    end
    // slave word arrives from the link side
    if (r_reg.rxt_s[2] != r_reg.rxt_s[1]) begin
      if (r_next.push) begin
        r_next.overrun = 1'b1;
      end else begin
        r_next.push      = 1'b1;
        r_next.push_data = lk_reg.rx_word;
      end
    end
    if (r_reg.hs_pend && r_reg.ack_s[1] == r_reg.htgl) begin
      r_next.hs_pend = 1'b0;
    end
    case (r_reg.st)
      M_IDLE: begin
        r_next.sclk = r_next.serial_control_reg.cpol;
        if (tx_valid_i && r_reg.tx_rdy) begin
          if (r_reg.serial_control_reg.master) begin
            r_next.st   = M_LEAD;
            r_next.hcnt = '0;
            r_next.bcnt = '0;
            r_next.busy = 1'b1;
            if (!r_reg.serial_control_reg.cpha) begin
              r_next.mosi = tx_word_i[W-1];
              r_next.txsh = {tx_word_i[W-2:0], 1'b0};
            end else begin
              r_next.txsh = tx_word_i;
            end
          end else begin
            r_next.slv_tx  = tx_word_i;
            r_next.htgl    = ~r_reg.htgl;
            r_next.hs_pend = 1'b1;
          end
        end
      end
      M_LEAD: begin
        if (r_reg.hcnt == half_m1) begin
          r_next.hcnt = '0;
          r_next.sclk = ~r_reg.sclk;
          r_next.st   = M_TRAIL;
          if (!r_reg.serial_control_reg.cpha) begin
            r_next.rxsh = {r_reg.rxsh[W-2:0], r_reg.miso_s[1]};
          end else begin
            r_next.mosi = r_reg.txsh[W-1];
            r_next.txsh = {r_reg.txsh[W-2:0], 1'b0};
          end
        end else begin
          r_next.hcnt = r_reg.hcnt + HW'(1);
        end
      end
      M_TRAIL: begin
        if (r_reg.hcnt == half_m1) begin
          r_next.hcnt = '0;
          r_next.sclk = ~r_reg.sclk;
          if (r_reg.serial_control_reg.cpha) begin
            r_next.rxsh = {r_reg.rxsh[W-2:0], r_reg.miso_s[1]};
          end else if (!last_bit) begin
            r_next.mosi = r_reg.txsh[W-1];
            r_next.txsh = {r_reg.txsh[W-2:0], 1'b0};
          end
          if (last_bit) begin
            r_next.st = M_DONE;
          end else begin
            r_next.bcnt = r_reg.bcnt + CW'(1);
            r_next.st   = M_LEAD;
          end
        end else begin
          r_next.hcnt = r_reg.hcnt + HW'(1);
        end
      end
      M_DONE: begin
        if (!r_reg.push || rx_in_if.ready) begin
          r_next.push      = 1'b1;
          r_next.push_data = r_reg.rxsh;
          r_next.st        = M_IDLE;
          r_next.busy      = 1'b0;
        end
      end
      default: begin
        r_next.st = M_IDLE;
      end
    endcase
    // contention for mastership aborts the word
    if (r_reg.serial_control_reg.master && !r_reg.ss_s[1]) begin
      r_next.mm_err = 1'b1;
      r_next.st     = M_IDLE;
      r_next.busy   = 1'b0;
      r_next.sclk   = r_reg.serial_control_reg.cpol;
    end
    r_next.sclk_oe = r_next.serial_control_reg.master;
    r_next.mosi_oe = r_next.serial_control_reg.master;
    r_next.miso_oe = !r_next.serial_control_reg.master && !r_reg.ss_s[1];
    r_next.tx_rdy  = (r_next.st == M_IDLE) &&
                     (r_next.serial_control_reg.master || !r_next.hs_pend) &&
                     !(tx_valid_i && r_reg.tx_rdy);
    for (int i = 0; i < `SPL_FLAG_N; i++) begin
      fmode = flag_mode_i[2*i +: 2];
      case (fmode)
        `SPL_FMODE_OUT: begin
          r_next.fl_oe[i] = 1'b1;
          r_next.fl_o[i]  = flag_out_val_i[i];
        end
        `SPL_FMODE_ALT: begin
          r_next.fl_oe[i] = (i == `SPL_TMR_PIN);
          r_next.fl_o[i]  = (i == `SPL_TMR_PIN) && timer_expiry_i;
        end
        `SPL_FMODE_SEL: begin
          r_next.fl_oe[i] = 1'b1;
          r_next.fl_o[i]  = !(r_next.busy && flag_sel_en_i[i]);
        end
        default: begin
          r_next.fl_oe[i] = 1'b0;
          r_next.fl_o[i]  = 1'b0;
        end
      endcase
      if (i < 3) begin
        r_next.irq[i] = (fmode == `SPL_FMODE_ALT) && !r_reg.fl_s2[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg                           <= '0;
      r_reg.ss_s                      <= 2'h3;
      r_reg.serial_control_reg.master <= `SPL_MASTER_RST;
      r_reg.serial_control_reg.cpol   <= `SPL_CPOL_RST;
      r_reg.serial_control_reg.cpha   <= `SPL_CPHA_RST;
      r_reg.serial_control_reg.div    <= `SPL_DIV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // link side: sample edge is the rising edge of slv_clk
  assign slv_clk     = serial_clock_pin_i ^
                       (r_reg.serial_control_reg.cpol ^ r_reg.serial_control_reg.cpha);
  assign frame_rst_n = rstn_i && !slave_select_input_n_i &&
                       !r_reg.serial_control_reg.master;

  always_comb begin
    fr_next     = fr_reg;
    fr_next.sh  = {fr_reg.sh[W-2:0], mosi_i};
    fr_next.cnt = (fr_reg.cnt == CW'(W - 1)) ? '0 : fr_reg.cnt + CW'(1);
    lk_next      = lk_reg;
    lk_next.hs_s = {lk_reg.hs_s[0], r_reg.htgl};
    if (fr_reg.cnt == CW'(W - 1)) begin
      lk_next.rx_word = {fr_reg.sh[W-2:0], mosi_i};
      lk_next.rxt     = ~lk_reg.rxt;
      if (lk_reg.hs_s[1] != lk_reg.ack) begin
        lk_next.tx_buf = r_reg.slv_tx;
        lk_next.ack    = lk_reg.hs_s[1];
      end
    end
  end

  always_ff @(posedge slv_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(posedge slv_clk or negedge rstn_i) begin
    if (!rstn_i) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // launch edge steps the outgoing bit
  always_ff @(negedge slv_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lcnt_reg <= '0;
    end else begin
      lcnt_reg <= (lcnt_reg == CW'(W - 1)) ? '0 : lcnt_reg + CW'(1);
    end
  end

  always_comb begin
    lidx = lcnt_reg;
    if (r_reg.serial_control_reg.cpha) begin
      lidx = (lcnt_reg == '0) ? CW'(W - 1) : lcnt_reg - CW'(1);
    end
  end

  assign miso_o                = lk_reg.tx_buf[CW'(W - 1) - lidx];
  assign miso_oe_o             = r_reg.miso_oe;
  assign serial_clock_pin_o    = r_reg.sclk;
  assign serial_clock_pin_oe_o = r_reg.sclk_oe;
  assign mosi_o                = r_reg.mosi;
  assign mosi_oe_o             = r_reg.mosi_oe;
  assign tx_ready_o            = r_reg.tx_rdy;
  assign busy_o                = r_reg.busy;
  assign mm_err_o              = r_reg.mm_err;
  assign overrun_o             = r_reg.overrun;
  assign flag_level_o          = r_reg.fl_s2;
  assign irq_req_o             = r_reg.irq;
  assign flag_pin_o            = r_reg.fl_o;
  assign flag_pin_oe_o         = r_reg.fl_oe;

  // checks
  logic [CW+1:0] tog_cnt;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tog_cnt <= '0;
    end else if (r_reg.st == M_IDLE) begin
      tog_cnt <= '0;
    end else if (r_next.sclk != r_reg.sclk) begin
      tog_cnt <= tog_cnt + (CW+2)'(1);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_clk_per_bit: assert property (r_reg.st == M_DONE |-> tog_cnt == (CW+2)'(2 * W))
    else $error("serial clock edge count differs from twice the word length");
  a_sclk_idle: assert property ((r_reg.st == M_IDLE) [*2]
    |-> serial_clock_pin_o == r_reg.serial_control_reg.cpol)
    else $error("serial clock not at idle level outside a transfer");
  a_mosi_launch: assert property ($changed(mosi_o) && $past(r_reg.st) != M_IDLE
    |-> $changed(serial_clock_pin_o))
    else $error("master data changed away from a serial clock edge");
  a_mm_flag: assert property (r_reg.serial_control_reg.master && !r_reg.ss_s[1]
    |=> mm_err_o && r_reg.st == M_IDLE)
    else $error("multimaster contention not flagged");
  a_master_pins: assert property (r_reg.serial_control_reg.master
    |-> mosi_oe_o && serial_clock_pin_oe_o && !miso_oe_o)
    else $error("master pin directions wrong");
  a_slave_idle: assert property (!r_reg.serial_control_reg.master && r_reg.ss_s[1]
    ##1 !r_reg.serial_control_reg.master |-> !miso_oe_o)
    else $error("unselected slave drives its data output");
  a_slave_sel: assert property (!r_reg.serial_control_reg.master && !r_reg.ss_s[1]
    ##1 !r_reg.serial_control_reg.master |-> miso_oe_o)
    else $error("selected slave does not drive its data output");
  a_flag_input: assert property (flag_mode_i == 8'h00 |=> flag_pin_oe_o == 4'h0)
    else $error("flag pin driven while set as input");
  a_sel_busy: assert property ($past(flag_mode_i[7:6] == `SPL_FMODE_SEL && flag_sel_en_i[3])
    && busy_o |-> !flag_pin_o[3])
    else $error("master select flag not low during a transfer");

  c_master_word: cover property (r_reg.st == M_DONE ##1 r_reg.st == M_IDLE);
  c_mm_error: cover property ($rose(mm_err_o));
  c_slave_word: cover property (r_reg.rxt_s[2] != r_reg.rxt_s[1]);
  c_buf_full: cover property (!rx_in_if.ready && rx_valid_o);
endmodule : spl_top
`default_nettype wire
